/* include/ptb_pkg.sv */
// Package: register map, field positions, reset values and carriers for the PWM time base
package ptb_pkg;

  localparam logic [3:0] ADDR_TIMER_CONTROL_ZERO = 4'h0;
  localparam logic [3:0] ADDR_TIMER_CONTROL_ONE = 4'h1;
  localparam logic [3:0] ADDR_PWM_CONTROL_ZERO = 4'h2;
  localparam logic [3:0] ADDR_PWM_CONTROL_ONE = 4'h3;
  localparam logic [3:0] ADDR_COUNTER_LOW = 4'h4;
  localparam logic [3:0] ADDR_COUNTER_HIGH = 4'h5;
  localparam logic [3:0] ADDR_PERIOD_LOW = 4'h6;
  localparam logic [3:0] ADDR_PERIOD_HIGH = 4'h7;
  localparam logic [3:0] ADDR_EVENT_STATUS = 4'h8;

  localparam int TB_WIDTH = 12;
  localparam int ENABLE_BIT = 7;
  localparam int DIR_BIT = 6;
  localparam int SEV_DIR_BIT = 3;
  localparam int BUFFER_UPDATE_DISABLE_BIT = 1;
  localparam int OVERRIDE_SYNC_BIT = 0;
  localparam logic [7:0] PWM_CONTROL_ONE_MASK = 8'hFB;
  localparam logic [7:0] PWM_CONTROL_ZERO_MASK = 8'h7F;

  localparam logic [7:0] RESET_CONTROL = 8'h00;
  localparam logic [2:0] PIN_ENABLE_ALL = 3'h5;
  localparam logic [2:0] PIN_ENABLE_NONE = 3'h0;
  localparam logic [11:0] RESET_PERIOD = 12'h000;

  localparam logic [1:0] MODE_FREE = 2'h0;
  localparam logic [1:0] MODE_SINGLE = 2'h1;
  localparam logic [1:0] MODE_UPDOWN = 2'h2;
  localparam logic [1:0] MODE_DOUBLE = 2'h3;

  localparam int PRESCALE_WIDTH = 6;
  localparam int POSTSCALE_WIDTH = 4;

  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } ptb_bus_req_t;

  typedef struct packed {
    logic [3:0] pair_independent;
    logic [2:0] output_pin_enable_field;
    logic special_event_trigger;
    logic buffer_update_disable;
    logic override_sync;
    logic outputs_inactive;
    logic load_duty;
    logic [11:0] time_base_counter;
  } ptb_pwm_ctl_t;

endpackage : ptb_pkg

/* design/ptb_divider.sv */
// Modulo event divider used for the prescaler and postscalers
`timescale 1ns/10ps
`default_nettype none
module ptb_divider #(
  parameter int WIDTH = 4
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic clear,
  input wire logic tick,
  input wire logic [WIDTH-1:0] ratio_m1,
  output logic fire
);
  typedef struct packed {
    logic [WIDTH-1:0] count;
  } ptb_div_state_t;

  ptb_div_state_t state_reg;
  ptb_div_state_t state_next;

  // Counts ticks, fires every ratio_m1+1 ticks
  always_comb begin
    state_next = state_reg;
    fire = 1'b0;
    if (clear) begin
      state_next.count = '0;
    end else if (tick) begin
      if (state_reg.count >= ratio_m1) begin
        state_next.count = '0;
        fire = 1'b1;
      end else begin
        state_next.count = state_reg.count + 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end
endmodule : ptb_divider
`default_nettype wire

/* design/ptb_count_core.sv */
// Twelve-bit time base counter with mode-dependent stepping
`timescale 1ns/10ps
`default_nettype none
module ptb_count_core #(
  parameter int WIDTH = 12
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic step,
  input wire logic [1:0] mode,
  input wire logic [WIDTH-1:0] period,
  input wire logic load,
  input wire logic [WIDTH-1:0] load_value,
  output logic [WIDTH-1:0] count,
  output logic down,
  output logic match,
  output logic wrap_zero,
  output logic turn_up
);
  typedef struct packed {
    logic [WIDTH-1:0] count;
    logic down;
  } ptb_core_state_t;

  ptb_core_state_t state_reg;
  ptb_core_state_t state_next;
  logic updown;

  assign count = state_reg.count;
  assign down = state_reg.down;
  assign updown = mode[1];

  always_comb begin
    state_next = state_reg;
    match = 1'b0;
    wrap_zero = 1'b0;
    turn_up = 1'b0;
    if (load) begin
      state_next.count = load_value;
    end else if (step) begin
      if (!updown) begin
        if (state_reg.count >= period) begin
          match = 1'b1;
          wrap_zero = 1'b1;
          state_next.count = '0; // see R7
        end else begin
          state_next.count = state_reg.count + 1'b1;
        end
      end else if (!state_reg.down) begin
        if (state_reg.count >= period) begin
          match = 1'b1;
          state_next.down = 1'b1; // see R9
          state_next.count = state_reg.count - 1'b1;
        end else begin
          state_next.count = state_reg.count + 1'b1;
        end
      end else begin
        if (state_reg.count <= {{(WIDTH-1){1'b0}}, 1'b1}) begin
          state_next.count = '0;
          state_next.down = 1'b0;
          turn_up = 1'b1;
        end else begin
          state_next.count = state_reg.count - 1'b1;
        end
      end
    end
    if (!updown) begin
      state_next.down = 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end
endmodule : ptb_count_core
`default_nettype wire

/* design/ptb_time_base.sv */
// PWM time base: prescaler, counter, period buffer, postscaler, events and control registers
// Summary of operation
// R1: Each pair mode bit: 1 independent pair, 0 complementary pair.
// R2: Output pin enable field resets from a configuration input, not a constant.
// R3: Special event postscale divides triggers 1:1 (0000) to 1:16 (1111).
// R4: Special event direction set fires only counting down, clear only up; set only counts at the period, which the down count never reaches.
// R5: Update disable blocks buffer to active transfers of duty and period.
// R6: Override sync set makes override changes follow the time base.
// R7: Free-running: count up to period, wrap to zero, keep counting.
// R8: Single-shot: count up, on match wrap to zero and clear enable.
// R9: Up/down modes: count up to period, then count down.
// R10: Direction status reads 1 counting down, 0 up; writes ignored.
// R11: Outputs held inactive for first half period after up/down enable.
// R12: Prescaler 1:1, 1:4, 1:16, 1:64 by codes 00 to 11.
// R13: Prescaler cleared by counter writes, control writes, reset; counter kept.
// R14: Match events pass a 4-bit postscaler, cleared like the prescaler.
// R15: Free-running: event each period match, rate cut by postscaler.
// R16: Single-shot: event on match, postscaler ignored.
// R17: Continuous up/down: event at zero turning up, postscaler applies.
// R18: Double update: events at zero and at period match.
// R19: Software clears enable before changing mode, then re-enables.
// R20: Period is 12 bits, high nibble plus low byte, buffered separately.
// R21: Period buffer loads at wrap, at zero in up/down, and while disabled.
// R22: The counter is 12 bits with prescaler and postscaler stages.
// R23: Enable runs the timer; clearing it stops but keeps the count.
// R24: Each event pulse sets a sticky flag that software clears.
//
// Added by the designer: the register addresses and the plain strobed port.
`timescale 1ns/10ps
`default_nettype none
module ptb_time_base #(
  parameter int TB_WIDTH = ptb_pkg::TB_WIDTH
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic pin_enable_reset_config,
  input wire logic [3:0] bus_addr,
  input wire logic [7:0] bus_wdata,
  input wire logic bus_wr,
  input wire logic bus_rd,
  output logic [7:0] bus_rdata,
  output logic time_base_event,
  output logic special_event_trigger,
  output logic [3:0] pair_mode_bits,
  output logic [2:0] output_pin_enable_field,
  output logic buffer_update_disable,
  output logic override_sync,
  output logic outputs_inactive,
  output logic load_duty,
  output logic [TB_WIDTH-1:0] time_base_counter
);
  typedef struct packed {
    logic [7:0] timer_control_zero;
    logic time_base_enable;
    logic [7:0] pwm_control_zero;
    logic [7:0] pwm_control_one;
    logic [TB_WIDTH-1:0] period_buffer;
    logic [TB_WIDTH-1:0] period_value;
    logic [7:0] counter_high_latch;
    logic first_half;
    logic event_flag;
    logic [7:0] rdata;
    logic time_base_event;
    logic special_event_trigger;
    logic load_duty;
    logic strap_done;
  } ptb_state_t;

  ptb_state_t state_reg;
  ptb_state_t state_next;
  ptb_pkg::ptb_bus_req_t req;
  ptb_pkg::ptb_pwm_ctl_t ctl;

  logic [1:0] mode;
  logic [1:0] prescale_sel;
  logic [3:0] postscale_sel;
  logic [ptb_pkg::PRESCALE_WIDTH-1:0] prescale_m1;
  logic scaler_clear;
  logic step;
  logic core_load;
  logic [TB_WIDTH-1:0] core_load_value;
  logic [TB_WIDTH-1:0] count;
  logic down;
  logic match;
  logic wrap_zero;
  logic turn_up;
  logic post_tick;
  logic post_fire;
  logic sev_tick;
  logic sev_fire;
  logic raw_event;
  logic period_load;

  assign req.addr = bus_addr;
  assign req.wdata = bus_wdata;
  assign req.wr = bus_wr;
  assign req.rd = bus_rd;

  assign mode = state_reg.timer_control_zero[1:0];
  assign prescale_sel = state_reg.timer_control_zero[3:2];
  assign postscale_sel = state_reg.timer_control_zero[7:4];

  // Prescale ratio minus one per select code
  always_comb begin
    case (prescale_sel) // see R12
      2'h0: prescale_m1 = 6'h00;
      2'h1: prescale_m1 = 6'h03;
      2'h2: prescale_m1 = 6'h0F;
      2'h3: prescale_m1 = 6'h3F;
      default: prescale_m1 = 6'h00;
    endcase
  end

  // Write to counter or either timer control register clears the prescaler and the match postscaler
  assign scaler_clear = req.wr && (req.addr == ptb_pkg::ADDR_TIMER_CONTROL_ZERO ||
    req.addr == ptb_pkg::ADDR_TIMER_CONTROL_ONE || req.addr == ptb_pkg::ADDR_COUNTER_LOW ||
    req.addr == ptb_pkg::ADDR_COUNTER_HIGH); // see R13 R14

  ptb_divider #(
    .WIDTH(ptb_pkg::PRESCALE_WIDTH)
  ) u_prescaler (
    .ref_clk(ref_clk),
    .rst(rst),
    .clear(scaler_clear),
    .tick(state_reg.time_base_enable), // see R23
    .ratio_m1(prescale_m1),
    .fire(step)
  );

  // Counter writes go through the high byte latch, low byte write loads all
  assign core_load = req.wr && req.addr == ptb_pkg::ADDR_COUNTER_LOW;
  assign core_load_value = {state_reg.counter_high_latch[TB_WIDTH-9:0], req.wdata};

  ptb_count_core #(
    .WIDTH(TB_WIDTH)
  ) u_core ( // see R22
    .ref_clk(ref_clk),
    .rst(rst),
    .step(step),
    .mode(mode),
    .period(state_reg.period_value),
    .load(core_load),
    .load_value(core_load_value),
    .count(count),
    .down(down),
    .match(match),
    .wrap_zero(wrap_zero),
    .turn_up(turn_up)
  );

  // Match source for the postscaler depends on the mode
  always_comb begin
    post_tick = 1'b0;
    raw_event = 1'b0;
    case (mode)
      ptb_pkg::MODE_FREE: post_tick = match; // see R15
      ptb_pkg::MODE_SINGLE: raw_event = match; // see R16
      ptb_pkg::MODE_UPDOWN: post_tick = turn_up; // see R17
      ptb_pkg::MODE_DOUBLE: raw_event = turn_up || match; // see R18
      default: raw_event = 1'b0;
    endcase
  end

  ptb_divider #(
    .WIDTH(ptb_pkg::POSTSCALE_WIDTH)
  ) u_postscaler (
    .ref_clk(ref_clk),
    .rst(rst),
    .clear(scaler_clear), // see R14
    .tick(post_tick),
    .ratio_m1(postscale_sel),
    .fire(post_fire)
  );

  // Special event trigger counts steps in the chosen direction at the period match point
  assign sev_tick = step && (state_reg.pwm_control_one[ptb_pkg::SEV_DIR_BIT] ? down : !down); // see R4

  ptb_divider #(
    .WIDTH(ptb_pkg::POSTSCALE_WIDTH)
  ) u_sev_postscaler (
    .ref_clk(ref_clk),
    .rst(rst),
    .clear(1'b0),
    .tick(sev_tick && count == state_reg.period_value),
    .ratio_m1(state_reg.pwm_control_one[7:4]), // see R3
    .fire(sev_fire)
  );

  // Period and duty transfers, blocked by update disable
  assign period_load = !state_reg.pwm_control_one[ptb_pkg::BUFFER_UPDATE_DISABLE_BIT] &&
    (!state_reg.time_base_enable || wrap_zero || turn_up); // see R5 R21

  always_comb begin
    state_next = state_reg;
    state_next.time_base_event = post_fire || raw_event;
    state_next.special_event_trigger = sev_fire;
    state_next.load_duty = period_load;
    state_next.rdata = 8'h00;
    if (period_load) begin
      state_next.period_value = state_reg.period_buffer; // see R21
    end
    if (mode == ptb_pkg::MODE_SINGLE && match) begin
      state_next.time_base_enable = 1'b0; // see R8
    end
    if (match) begin
      state_next.first_half = 1'b0; // see R11
    end
    // Strap taken once, on the first edge after reset
    if (!state_reg.strap_done) begin
      state_next.strap_done = 1'b1;
      state_next.pwm_control_zero[6:4] = pin_enable_reset_config ?
        ptb_pkg::PIN_ENABLE_ALL : ptb_pkg::PIN_ENABLE_NONE; // see R2
    end
    if (req.wr) begin
      case (req.addr)
        ptb_pkg::ADDR_TIMER_CONTROL_ZERO: state_next.timer_control_zero = req.wdata;
        ptb_pkg::ADDR_TIMER_CONTROL_ONE: begin
          state_next.time_base_enable = req.wdata[ptb_pkg::ENABLE_BIT]; // see R10 R19 R23
          if (req.wdata[ptb_pkg::ENABLE_BIT] && !state_reg.time_base_enable) begin
            state_next.first_half = mode[1]; // see R11
          end
        end
        ptb_pkg::ADDR_PWM_CONTROL_ZERO: state_next.pwm_control_zero = req.wdata & ptb_pkg::PWM_CONTROL_ZERO_MASK;
        ptb_pkg::ADDR_PWM_CONTROL_ONE: state_next.pwm_control_one = req.wdata & ptb_pkg::PWM_CONTROL_ONE_MASK;
        ptb_pkg::ADDR_COUNTER_HIGH: state_next.counter_high_latch = req.wdata;
        ptb_pkg::ADDR_PERIOD_LOW: state_next.period_buffer[7:0] = req.wdata; // see R20
        ptb_pkg::ADDR_PERIOD_HIGH: state_next.period_buffer[TB_WIDTH-1:8] = req.wdata[TB_WIDTH-9:0];
        ptb_pkg::ADDR_EVENT_STATUS: begin
          if (req.wdata[0]) begin
            state_next.event_flag = 1'b0;
          end
        end
        default: state_next.event_flag = state_next.event_flag;
      endcase
    end
    // Hardware set of the sticky flag wins over a clear
    if (state_reg.time_base_event) begin
      state_next.event_flag = 1'b1; // see R24
    end
    if (req.rd) begin
      case (req.addr)
        ptb_pkg::ADDR_TIMER_CONTROL_ZERO: state_next.rdata = state_reg.timer_control_zero;
        ptb_pkg::ADDR_TIMER_CONTROL_ONE: state_next.rdata = {state_reg.time_base_enable, down, 6'h00}; // see R10
        ptb_pkg::ADDR_PWM_CONTROL_ZERO: state_next.rdata = state_reg.pwm_control_zero;
        ptb_pkg::ADDR_PWM_CONTROL_ONE: state_next.rdata = state_reg.pwm_control_one;
        ptb_pkg::ADDR_COUNTER_LOW: state_next.rdata = count[7:0];
        ptb_pkg::ADDR_COUNTER_HIGH: state_next.rdata = {4'h0, count[TB_WIDTH-1:8]};
        ptb_pkg::ADDR_PERIOD_LOW: state_next.rdata = state_reg.period_buffer[7:0];
        ptb_pkg::ADDR_PERIOD_HIGH: state_next.rdata = {4'h0, state_reg.period_buffer[TB_WIDTH-1:8]};
        ptb_pkg::ADDR_EVENT_STATUS: state_next.rdata = {7'h00, state_reg.event_flag};
        default: state_next.rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state_reg <= '0;
      state_reg.period_value <= ptb_pkg::RESET_PERIOD;
    end else begin
      state_reg <= state_next;
    end
  end

  // Output carrier, all fields from flip-flops
  always_comb begin
    ctl.pair_independent = state_reg.pwm_control_zero[3:0]; // see R1
    ctl.output_pin_enable_field = state_reg.pwm_control_zero[6:4];
    ctl.special_event_trigger = state_reg.special_event_trigger;
    ctl.buffer_update_disable = state_reg.pwm_control_one[ptb_pkg::BUFFER_UPDATE_DISABLE_BIT];
    ctl.override_sync = state_reg.pwm_control_one[ptb_pkg::OVERRIDE_SYNC_BIT]; // see R6
    ctl.outputs_inactive = state_reg.first_half; // see R11
    ctl.load_duty = state_reg.load_duty;
    ctl.time_base_counter = count;
  end

  assign bus_rdata = state_reg.rdata;
  assign time_base_event = state_reg.time_base_event;
  assign special_event_trigger = ctl.special_event_trigger;
  assign pair_mode_bits = ctl.pair_independent;
  assign output_pin_enable_field = ctl.output_pin_enable_field;
  assign buffer_update_disable = ctl.buffer_update_disable;
  assign override_sync = ctl.override_sync;
  assign outputs_inactive = ctl.outputs_inactive;
  assign load_duty = ctl.load_duty;
  assign time_base_counter = ctl.time_base_counter;
endmodule : ptb_time_base
`default_nettype wire

/* bench/ptb_time_base_properties.sv */
// Checker: port-level properties of the PWM time base
`timescale 1ns/10ps
`default_nettype none
module ptb_time_base_properties #(
  parameter int TB_WIDTH = 12
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic pin_enable_reset_config,
  input wire logic [3:0] bus_addr,
  input wire logic [7:0] bus_wdata,
  input wire logic bus_wr,
  input wire logic bus_rd,
  input wire logic [7:0] bus_rdata,
  input wire logic time_base_event,
  input wire logic special_event_trigger,
  input wire logic [3:0] pair_mode_bits,
  input wire logic [2:0] output_pin_enable_field,
  input wire logic buffer_update_disable,
  input wire logic override_sync,
  input wire logic outputs_inactive,
  input wire logic load_duty,
  input wire logic [TB_WIDTH-1:0] time_base_counter
);
  logic en_reg;
  logic en_prev_reg;
  logic cnt_wr;
  assign cnt_wr = bus_wr && (bus_addr[3:1] == 3'h2);
  // Enable as last written by software
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      en_reg <= 1'b0;
      en_prev_reg <= 1'b0;
    end else begin
      if (bus_wr && bus_addr == ptb_pkg::ADDR_TIMER_CONTROL_ONE) begin
        en_reg <= bus_wdata[ptb_pkg::ENABLE_BIT];
      end
      en_prev_reg <= en_reg;
    end
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  a_pin_enable_strap: assert property ($fell(rst) |-> ##[1:2] output_pin_enable_field ==
    (pin_enable_reset_config ? ptb_pkg::PIN_ENABLE_ALL : ptb_pkg::PIN_ENABLE_NONE))
    else $error("pin enable field not loaded from strap");
  a_pair_mode_write: assert property (bus_wr && bus_addr == ptb_pkg::ADDR_PWM_CONTROL_ZERO
    |=> pair_mode_bits == $past(bus_wdata[3:0])) else $error("pair mode bits wrong");
  a_buffer_update_disable_write: assert property (bus_wr && bus_addr == ptb_pkg::ADDR_PWM_CONTROL_ONE
    |=> buffer_update_disable == $past(bus_wdata[1])) else $error("update disable wrong");
  a_override_sync_write: assert property (bus_wr && bus_addr == ptb_pkg::ADDR_PWM_CONTROL_ONE
    |=> override_sync == $past(bus_wdata[0])) else $error("override sync wrong");
  a_count_step: assert property (!cnt_wr && !$past(cnt_wr) && !$past(cnt_wr, 2) |=>
    (time_base_counter == $past(time_base_counter) || time_base_counter == 12'h000 ||
    time_base_counter == $past(time_base_counter) + 12'h001 ||
    time_base_counter == $past(time_base_counter) - 12'h001)) else $error("counter jumped");
  a_count_hold_off: assert property (!bus_wr && !en_reg && !en_prev_reg && !$past(cnt_wr) &&
    !$past(cnt_wr, 2) |=> $stable(time_base_counter)) else $error("counter moved while off");
  a_event_pulse: assert property (time_base_event |=> !time_base_event)
    else $error("event longer than one cycle");
  a_sev_pulse: assert property (special_event_trigger |=> !special_event_trigger)
    else $error("trigger longer than one cycle");
  c_event: cover property (time_base_event);
  c_trigger: cover property (special_event_trigger);
  c_inactive: cover property ($rose(outputs_inactive));
endmodule : ptb_time_base_properties
bind ptb_time_base ptb_time_base_properties #(.TB_WIDTH(TB_WIDTH)) i_props (.ref_clk, .rst,
  .pin_enable_reset_config, .bus_addr, .bus_wdata, .bus_wr, .bus_rd, .bus_rdata, .time_base_event,
  .special_event_trigger, .pair_mode_bits, .output_pin_enable_field, .buffer_update_disable,
  .override_sync, .outputs_inactive, .load_duty, .time_base_counter);
`default_nettype wire

/* bench/ptb_switch_stage.sv */
// Partner: switching stage that follows pair modes once outputs are released
`timescale 1ns/10ps
`default_nettype none
module ptb_switch_stage (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic outputs_inactive,
  input wire logic [3:0] pair_mode_bits,
  output logic [3:0] independent_pairs
);
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      independent_pairs <= 4'h0;
    end else if (!outputs_inactive) begin
      independent_pairs <= pair_mode_bits;
    end
  end
endmodule : ptb_switch_stage
`default_nettype wire

/* bench/ptb_time_base_bench.sv */
// Testbench: registers, counting modes and events of the PWM time base
`timescale 1ns/10ps
`default_nettype none
module ptb_time_base_bench;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic pin_enable_reset_config = 1'b1;
  logic [3:0] bus_addr = 4'h0;
  logic [7:0] bus_wdata = 8'h00;
  logic bus_wr = 1'b0;
  logic bus_rd = 1'b0;
  logic [7:0] bus_rdata;
  logic time_base_event, special_event_trigger, buffer_update_disable, override_sync;
  logic outputs_inactive, load_duty;
  logic [3:0] pair_mode_bits, pairs_seen;
  logic [2:0] output_pin_enable_field;
  logic [11:0] time_base_counter, cnt_max;
  logic [7:0] rv;
  logic inact_seen;
  int fails = 0;
  int check_count = 0;
  int ev_n, sev_n;

  always #2.5 ref_clk = ~ref_clk;

  ptb_time_base i_dut (.ref_clk, .rst, .pin_enable_reset_config, .bus_addr, .bus_wdata, .bus_wr,
    .bus_rd, .bus_rdata, .time_base_event, .special_event_trigger, .pair_mode_bits,
    .output_pin_enable_field, .buffer_update_disable, .override_sync, .outputs_inactive,
    .load_duty, .time_base_counter);
  ptb_switch_stage i_stage (.ref_clk, .rst, .outputs_inactive, .pair_mode_bits,
    .independent_pairs(pairs_seen));

  task automatic test_done;
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : test_done

  task automatic chk(input logic [11:0] seen, input logic [11:0] exp);
    check_count++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    bus_addr <= a;
    bus_wdata <= d;
    bus_wr <= 1'b1;
    @(posedge ref_clk);
    bus_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [3:0] a);
    @(posedge ref_clk);
    bus_addr <= a;
    bus_rd <= 1'b1;
    @(posedge ref_clk);
    bus_rd <= 1'b0;
    @(negedge ref_clk);
    rv = bus_rdata;
  endtask : rd

  // Counts events and peak count over n cycles
  task automatic watch(input int n);
    ev_n = 0;
    sev_n = 0;
    cnt_max = 12'h000;
    inact_seen = 1'b0;
    repeat (n) begin
      @(negedge ref_clk);
      ev_n = ev_n + int'(time_base_event === 1'b1);
      sev_n = sev_n + int'(special_event_trigger === 1'b1);
      cnt_max = (time_base_counter > cnt_max) ? time_base_counter : cnt_max;
      inact_seen = inact_seen | (outputs_inactive === 1'b1);
    end
  endtask : watch

  task automatic run(input logic [7:0] ctl, input logic [7:0] per, input int win, input int ev,
    input logic [11:0] mx, input int sv);
    wr(ptb_pkg::ADDR_PERIOD_LOW, per);
    wr(ptb_pkg::ADDR_TIMER_CONTROL_ZERO, ctl);
    wr(ptb_pkg::ADDR_TIMER_CONTROL_ONE, 8'h80);
    watch(win);
    chk(12'(inact_seen), 12'(ctl[1]));
    watch(win);
    chk(12'(ev_n), 12'(ev));
    chk(cnt_max, mx);
    if (sv >= 0) begin
      chk(12'(sev_n), 12'(sv));
    end
    wr(ptb_pkg::ADDR_TIMER_CONTROL_ONE, 8'h00);
  endtask : run

  task automatic reg_checks;
    for (int i = 0; i < 16; i++) begin
      rd(4'(i));
      chk(12'(rv), (i == 2) ? 12'h050 : 12'h000);
    end
    wr(ptb_pkg::ADDR_PWM_CONTROL_ONE, 8'hFF);
    wr(ptb_pkg::ADDR_PWM_CONTROL_ZERO, 8'hDA);
    wr(ptb_pkg::ADDR_TIMER_CONTROL_ONE, 8'h40);
    wr(4'hF, 8'hFF);
    rd(ptb_pkg::ADDR_TIMER_CONTROL_ONE);
    chk(12'(rv), 12'h000);
    rd(ptb_pkg::ADDR_PWM_CONTROL_ONE);
    chk(12'(rv), 12'h0FB);
    rd(ptb_pkg::ADDR_PWM_CONTROL_ZERO);
    chk(12'(rv), 12'h05A);
    chk(12'({buffer_update_disable, override_sync}), 12'h003);
    chk(12'(pairs_seen), 12'h00A);
    rd(4'hF);
    chk(12'(rv), 12'h000);
    wr(ptb_pkg::ADDR_PWM_CONTROL_ONE, 8'h00);
  endtask : reg_checks

  task automatic single_shot;
    wr(ptb_pkg::ADDR_COUNTER_HIGH, 8'h00);
    wr(ptb_pkg::ADDR_COUNTER_LOW, 8'h00);
    wr(ptb_pkg::ADDR_PERIOD_LOW, 8'h03);
    wr(ptb_pkg::ADDR_TIMER_CONTROL_ZERO, 8'hF1);
    wr(ptb_pkg::ADDR_TIMER_CONTROL_ONE, 8'h80);
    watch(40);
    chk(12'(ev_n), 12'h001);
    chk(cnt_max, 12'h003);
    chk(time_base_counter, 12'h000);
    rd(ptb_pkg::ADDR_TIMER_CONTROL_ONE);
    chk(12'(rv), 12'h000);
  endtask : single_shot

  task automatic dir_scan;
    logic dir_or;
    logic dir_and;
    logic [11:0] held;
    dir_or = 1'b0;
    dir_and = 1'b1;
    wr(ptb_pkg::ADDR_TIMER_CONTROL_ZERO, 8'h02);
    wr(ptb_pkg::ADDR_TIMER_CONTROL_ONE, 8'h80);
    repeat (12) begin
      rd(ptb_pkg::ADDR_TIMER_CONTROL_ONE);
      dir_or = dir_or | rv[6];
      dir_and = dir_and & rv[6];
    end
    chk(12'({dir_or, dir_and}), 12'h002);
    wr(ptb_pkg::ADDR_TIMER_CONTROL_ONE, 8'h00);
    @(negedge ref_clk);
    held = time_base_counter;
    repeat (20) @(negedge ref_clk);
    chk(time_base_counter, held);
  endtask : dir_scan

  task automatic buffer_update_disable_hold;
    wr(ptb_pkg::ADDR_PERIOD_LOW, 8'h05);
    wr(ptb_pkg::ADDR_TIMER_CONTROL_ZERO, 8'h00);
    wr(ptb_pkg::ADDR_TIMER_CONTROL_ONE, 8'h80);
    wr(ptb_pkg::ADDR_PWM_CONTROL_ONE, 8'h02);
    wr(ptb_pkg::ADDR_PERIOD_LOW, 8'h02);
    watch(24);
    chk(cnt_max, 12'h005);
    wr(ptb_pkg::ADDR_PWM_CONTROL_ONE, 8'h00);
    watch(12);
    watch(24);
    chk(cnt_max, 12'h002);
    wr(ptb_pkg::ADDR_TIMER_CONTROL_ONE, 8'h00);
  endtask : buffer_update_disable_hold

  task automatic flag_and_counter;
    rd(ptb_pkg::ADDR_EVENT_STATUS);
    chk(12'(rv), 12'h001);
    wr(ptb_pkg::ADDR_EVENT_STATUS, 8'h01);
    rd(ptb_pkg::ADDR_EVENT_STATUS);
    chk(12'(rv), 12'h000);
    wr(ptb_pkg::ADDR_COUNTER_HIGH, 8'h01);
    wr(ptb_pkg::ADDR_COUNTER_LOW, 8'h23);
    @(negedge ref_clk);
    chk(time_base_counter, 12'h123);
    rd(ptb_pkg::ADDR_COUNTER_LOW);
    chk(12'(rv), 12'h023);
  endtask : flag_and_counter

  // Transfer level while off, then a reset with the strap low
  task automatic strap_reset;
    chk(12'(load_duty), 12'h001);
    @(posedge ref_clk);
    pin_enable_reset_config <= 1'b0;
    rst <= 1'b1;
    repeat (3) @(posedge ref_clk);
    rst <= 1'b0;
    rd(ptb_pkg::ADDR_PWM_CONTROL_ZERO);
    chk(12'(rv), 12'h000);
    chk(12'(output_pin_enable_field), 12'(ptb_pkg::PIN_ENABLE_NONE));
    chk(12'(pair_mode_bits), 12'h000);
  endtask : strap_reset

  initial begin
    repeat (10) @(posedge ref_clk);
    rst <= 1'b0;
    reg_checks();
    for (int p = 0; p < 4; p++) begin
      run({4'h0, 2'(p), 2'b00}, 8'h05, 12 << (2 * p), 2, 12'h005, 2);
    end
    run(8'hF0, 8'h05, 192, 2, 12'h005, 32);
    wr(ptb_pkg::ADDR_PWM_CONTROL_ONE, 8'h10);
    run(8'h00, 8'h05, 12, 2, 12'h005, 1);
    wr(ptb_pkg::ADDR_PWM_CONTROL_ONE, 8'h00);
    single_shot();
    run(8'h02, 8'h04, 16, 2, 12'h004, -1);
    run(8'h03, 8'h04, 16, 4, 12'h004, -1);
    dir_scan();
    buffer_update_disable_hold();
    flag_and_counter();
    strap_reset();
    test_done();
  end
endmodule : ptb_time_base_bench
`default_nettype wire
